// ### common/hcgm_pkg.sv
// Constants, field layout and carrier types of the host control and output-pin select block.
// Assumes one 25 MHz clock and an AXI4-Lite register port with 32-bit data.
package hcgm_pkg;

    // ==========================================================
    // Bus and register map
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] IDX_HOST_CTRL = 12'h040;
    localparam logic [ADDR_W-1:0] IDX_PIN_SEL = 12'h042;
    localparam logic [ADDR_W-1:0] ADDR_HOST_CTRL = IDX_HOST_CTRL << 2;
    localparam logic [ADDR_W-1:0] ADDR_PIN_SEL = IDX_PIN_SEL << 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Host control fields
    localparam int HC_FLAG_BIT = 0;
    localparam int HC_MASK_BIT = 1;
    localparam int HC_LPS_BIT = 2;
    localparam int HC_SRST_BIT = 3;
    localparam logic [31:0] HOST_CTRL_RST = 32'h0000_0000;
    localparam logic LINK_POWER_STATUS_ENABLE_RST = 1'b1;

    // ==========================================================
    // Output-pin select fields
    localparam int SEL_W = 5;
    localparam int NUM_PINS = 3;
    localparam int SEL_A_LSB = 27;
    localparam int SEL_B_LSB = 19;
    localparam int SEL_C_LSB = 11;
    localparam logic [31:0] PIN_SEL_RST = 32'h0000_0000;
    localparam logic [31:0] PIN_SEL_WMASK = 32'hF8F8_F800;

    localparam logic [SEL_W-1:0] SEL_LEGACY = 5'h00;
    localparam logic [SEL_W-1:0] SEL_CYC_DONE = 5'h01;
    localparam logic [SEL_W-1:0] SEL_GRF_EMPTY = 5'h02;
    localparam logic [SEL_W-1:0] SEL_CYC_STARTED = 5'h03;
    localparam logic [SEL_W-1:0] SEL_ATF_FULL = 5'h04;
    localparam logic [SEL_W-1:0] SEL_ATF_EMPTY = 5'h05;
    localparam logic [SEL_W-1:0] SEL_ITF_FULL = 5'h06;
    localparam logic [SEL_W-1:0] SEL_ITF_EMPTY = 5'h07;
    localparam logic [SEL_W-1:0] SEL_ACK_RCVD = 5'h08;
    localparam logic [SEL_W-1:0] SEL_LINK_HALF = 5'h09;
    localparam logic [SEL_W-1:0] SEL_ARB_GAP = 5'h0A;
    localparam logic [SEL_W-1:0] SEL_FAIR_GAP = 5'h0B;
    localparam logic [SEL_W-1:0] SEL_GRF_CONFIRM = 5'h0C;
    localparam logic [SEL_W-1:0] SEL_PKT_DONE = 5'h0D;
    localparam logic [SEL_W-1:0] SEL_CONST_LO = 5'h0E;
    localparam logic [SEL_W-1:0] SEL_CONST_HI = 5'h0F;
    localparam logic [SEL_W-1:0] SEL_TOKEN = 5'h10;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic cycle_done;
        logic cycle_start;
        logic cycle_started;
        logic grf_empty;
        logic atf_full;
        logic atf_empty;
        logic itf_full;
        logic itf_empty;
        logic ack_received;
        logic link_clk_half;
        logic arbitration_gap;
        logic fairness_gap;
        logic grf_confirm;
        logic packet_complete_flag;
        logic token_at_head_flag;
    } hcgm_src_t;

    typedef struct packed {
        logic soft_reset;
        logic link_power_status_enable;
        logic access_fail_mask;
        logic access_fail_flag;
    } hcgm_hc_t;

endpackage

// ### hw/hcgm_pin_sel.sv
// One output-pin source selector, decoding a 5-bit select code.
// Assumes its sources are already synchronous to the host clock.
`timescale 1ns/1ps
module hcgm_pin_sel #(
    parameter int PIN = 0
) (
    input wire logic [hcgm_pkg::SEL_W-1:0] sel,
    input wire hcgm_pkg::hcgm_src_t src,
    output logic pin_level
);
    import hcgm_pkg::*;

    logic legacy;
    logic top_default;

    // ==========================================================
    // Per-pin legacy source
    always_comb
    begin
        legacy = src.cycle_start;
        top_default = src.cycle_start;
        case (PIN)
            0:
            begin
                legacy = src.grf_empty;
                top_default = src.grf_empty;
            end
            1:
            begin
                legacy = src.cycle_done;
                top_default = src.cycle_done;
            end
            default:
            begin
                legacy = src.cycle_start;
                // 1xxx0 is not defined for this pin; treat like the legacy code
                top_default = sel[0] ? src.cycle_started : src.cycle_start;
            end
        endcase
    end

    // ==========================================================
    // Code decode
    always_comb
    begin
        case (sel)
            SEL_LEGACY: pin_level = legacy;
            SEL_CYC_DONE: pin_level = src.cycle_done;
            SEL_GRF_EMPTY: pin_level = src.grf_empty;
            SEL_CYC_STARTED: pin_level = src.cycle_started;
            SEL_ATF_FULL: pin_level = src.atf_full;
            SEL_ATF_EMPTY: pin_level = src.atf_empty;
            SEL_ITF_FULL: pin_level = src.itf_full;
            SEL_ITF_EMPTY: pin_level = src.itf_empty;
            SEL_ACK_RCVD: pin_level = src.ack_received;
            SEL_LINK_HALF: pin_level = src.link_clk_half;
            SEL_ARB_GAP: pin_level = src.arbitration_gap;
            SEL_FAIR_GAP: pin_level = src.fairness_gap;
            SEL_GRF_CONFIRM: pin_level = src.grf_confirm;
            SEL_PKT_DONE: pin_level = src.packet_complete_flag;
            SEL_CONST_LO: pin_level = 1'b0;
            SEL_CONST_HI: pin_level = 1'b1;
            SEL_TOKEN: pin_level = src.token_at_head_flag;
            default: pin_level = top_default;
        endcase
    end

endmodule

// ### hw/hcgm_top.sv
// Host control register and output-pin select register with AXI4-Lite access.
// Assumes link-side sources arrive as levels and are resynchronised here.
`timescale 1ns/1ps
module hcgm_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [hcgm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [hcgm_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic link_reg_access,
    input wire logic link_clk_running,
    input wire logic diag_register_write_override,
    input wire hcgm_pkg::hcgm_src_t link_src,
    output logic link_soft_reset,
    output logic link_power_status_enable,
    output logic irq,
    output logic [hcgm_pkg::NUM_PINS-1:0] general_out_pins
);
    import hcgm_pkg::*;

    // ==========================================================
    // Reset release
    logic rst_s1_q;
    logic rst_n;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // ==========================================================
    // AXI4-Lite write channel
    logic aw_held_q, aw_held_d;
    logic w_held_q, w_held_d;
    logic [ADDR_W-1:0] waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic wr_fire;
    logic wr_host;
    logic wr_sel;
    logic [31:0] byte_mask;

    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wr_host = wr_fire && waddr_q[ADDR_W-1:2] == ADDR_HOST_CTRL[ADDR_W-1:2];
    assign wr_sel = wr_fire && waddr_q[ADDR_W-1:2] == ADDR_PIN_SEL[ADDR_W-1:2];

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++)
        begin : g_lane
            assign byte_mask[gb*8 +: 8] = {8{wstrb_q[gb]}};
        end
    endgenerate

    always_comb
    begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_bvalid && s_axi_bready)
            bvalid_d = 1'b0;
        if (wr_fire)
        begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (wr_host || wr_sel) ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_axi_awvalid && awready_q)
        begin
            aw_held_d = 1'b1;
            waddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q)
        begin
            w_held_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        awready_d = !aw_held_d;
        wready_d = !w_held_d;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
        end
        else
        begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
        end
    end

    // ==========================================================
    // Register state
    hcgm_hc_t hc_q, hc_d;
    logic [31:0] sel_q, sel_d;
    logic hc_lane0;
    logic fail_evt;

    assign hc_lane0 = wr_host && wstrb_q[0];
    assign fail_evt = link_reg_access && !link_clk_running;

    always_comb
    begin
        hc_d = hc_q;
        sel_d = sel_q;
        if (hc_lane0)
        begin
            if (diag_register_write_override)
                hc_d.access_fail_flag = wdata_q[HC_FLAG_BIT];
            else if (wdata_q[HC_FLAG_BIT])
                hc_d.access_fail_flag = 1'b0;
            hc_d.soft_reset = wdata_q[HC_SRST_BIT];
            // Fail mask frozen while soft reset already holds
            if (!hc_q.soft_reset)
                hc_d.access_fail_mask = wdata_q[HC_MASK_BIT];
            if (wdata_q[HC_LPS_BIT])
                hc_d.link_power_status_enable = 1'b1;
        end
        if (fail_evt)
            hc_d.access_fail_flag = 1'b1;
        if (hc_d.soft_reset)
            hc_d.link_power_status_enable = 1'b0;
        if (wr_sel && !hc_q.soft_reset)
            sel_d = (sel_q & ~(byte_mask & PIN_SEL_WMASK)) | (wdata_q & byte_mask & PIN_SEL_WMASK);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hc_q <= hcgm_hc_t'(HOST_CTRL_RST[3:0]);
            hc_q.link_power_status_enable <= LINK_POWER_STATUS_ENABLE_RST;
            sel_q <= PIN_SEL_RST;
        end
        else
        begin
            hc_q <= hc_d;
            sel_q <= sel_d;
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic arready_q, arready_d;

    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_rvalid && s_axi_rready)
            rvalid_d = 1'b0;
        if (s_axi_arvalid && arready_q)
        begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            if (s_axi_araddr[ADDR_W-1:2] == ADDR_HOST_CTRL[ADDR_W-1:2])
                rdata_d = {28'h0000000, hc_q};
            else if (s_axi_araddr[ADDR_W-1:2] == ADDR_PIN_SEL[ADDR_W-1:2])
                rdata_d = sel_q;
            else
            begin
                rdata_d = 32'h0000_0000;
                rresp_d = RESP_SLVERR;
            end
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            arready_q <= arready_d;
        end
    end

    // ==========================================================
    // Source synchronisers and output pins
    hcgm_src_t src_s1_q;
    hcgm_src_t src_s2_q;
    logic [NUM_PINS-1:0] pins_q, pins_d;
    logic irq_q, irq_d;
    logic [SEL_W-1:0] pin_code [NUM_PINS];

    // Link-side levels cross here; the half-rate clock is only as good as two flops allow
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            src_s1_q <= '0;
            src_s2_q <= '0;
        end
        else
        begin
            src_s1_q <= link_src;
            src_s2_q <= src_s1_q;
        end
    end

    assign pin_code[0] = sel_q[SEL_A_LSB +: SEL_W];
    assign pin_code[1] = sel_q[SEL_B_LSB +: SEL_W];
    assign pin_code[2] = sel_q[SEL_C_LSB +: SEL_W];

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++)
        begin : g_pin
            hcgm_pin_sel #(
                .PIN(gp)
            ) u_sel (
                .sel(pin_code[gp]),
                .src(src_s2_q),
                .pin_level(pins_d[gp])
            );
        end
    endgenerate

    assign irq_d = hc_q.access_fail_flag && hc_q.access_fail_mask;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pins_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            pins_q <= pins_d;
            irq_q <= irq_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign link_soft_reset = hc_q.soft_reset;
    assign link_power_status_enable = hc_q.link_power_status_enable;
    assign irq = irq_q;
    assign general_out_pins = pins_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_flag_set_fail: assert property (fail_evt |=> hc_q.access_fail_flag)
        else $error("access fail flag not set");
    a_flag_w1c: assert property (hc_lane0 && wdata_q[HC_FLAG_BIT] && !fail_evt
        && !diag_register_write_override |=> !hc_q.access_fail_flag)
        else $error("flag not cleared by write one");
    a_flag_w0_keep: assert property (hc_q.access_fail_flag && hc_lane0 && !wdata_q[HC_FLAG_BIT]
        && !diag_register_write_override |=> hc_q.access_fail_flag)
        else $error("flag lost on write zero");
    a_irq_follow: assert property (hc_q.access_fail_flag && hc_q.access_fail_mask |=> irq ##1 irq || !irq_d)
        else $error("interrupt not raised");
    a_irq_masked: assert property (!hc_q.access_fail_mask |=> !irq)
        else $error("interrupt while masked");
    a_lps_srst_low: assert property (hc_q.soft_reset |-> !link_power_status_enable)
        else $error("power enable set in soft reset");
    a_lps_w0_keep: assert property (hc_q.link_power_status_enable && hc_lane0 && !wdata_q[HC_SRST_BIT]
        |=> hc_q.link_power_status_enable)
        else $error("power enable lost on write");
    a_srst_hold: assert property (hc_q.soft_reset && !hc_lane0 |=> hc_q.soft_reset)
        else $error("soft reset dropped");
    a_sel_frozen: assert property (hc_q.soft_reset |=> $stable(sel_q))
        else $error("select changed in soft reset");
    a_sel_reserved: assert property ((sel_q & ~PIN_SEL_WMASK) == 32'h0000_0000)
        else $error("reserved select bits set");
    a_pin_const: assert property (pin_code[0] == SEL_CONST_HI ##1 pin_code[0] == SEL_CONST_HI
        |-> general_out_pins[0])
        else $error("constant high not driven");
    a_pin_token: assert property (pin_code[1] == SEL_TOKEN && $stable(pin_code[1])
        |=> general_out_pins[1] == $past(src_s2_q.token_at_head_flag))
        else $error("token flag not routed");

    c_fail_irq: cover property (fail_evt && hc_q.access_fail_mask ##2 irq);
    c_soft_reset: cover property (hc_lane0 && wdata_q[HC_SRST_BIT] ##1 link_soft_reset);
    c_sel_write: cover property (wr_sel ##1 sel_q != PIN_SEL_RST);
    c_read_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule

// ### tb/hcgm_host_model.sv
// Host processor model: an AXI4-Lite master whose tasks the bench calls.
// Assumes the block's single clock; released lines carry inverted data.
`timescale 1ns/1ps
module hcgm_host_model (
    input wire logic clk,
    output logic [hcgm_pkg::ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [hcgm_pkg::ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    import hcgm_pkg::*;
    logic aw_hs, w_hs, b_hs, r_hs;
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // ==========================================================
    // Write: handshakes sampled mid-cycle, released at the taking edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge clk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid && bready;
            r = bresp;
            @(posedge clk);
            if (aw_hs)
                {awvalid, awaddr} <= {1'b0, ~a};
            if (w_hs)
                {wvalid, wdata} <= {1'b0, ~d};
            if (b_hs)
                bready <= 1'b0;
        end while (!b_hs);
    endtask
    // ==========================================================
    // Read
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge clk);
            aw_hs = arvalid && arready;
            r_hs = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (aw_hs)
                {arvalid, araddr} <= {1'b0, ~a};
            if (r_hs)
                rready <= 1'b0;
        end while (!r_hs);
    endtask
endmodule

// ### tb/tb_host_control_and_gpo_mux.sv
// Self-checking bench for the host control and output-pin select block.
// Assumes the host model drives the register port; link sources from here.
`timescale 1ns/1ps
module tb_host_control_and_gpo_mux;
    import hcgm_pkg::*;
    logic clk, nrst, link_reg_access, link_clk_running, diag_register_write_override;
    hcgm_src_t link_src;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic link_soft_reset, link_power_status_enable, irq;
    logic [NUM_PINS-1:0] general_out_pins;
    int errors = 0;
    int n_compared = 0;
    hcgm_top dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .link_reg_access, .link_clk_running, .diag_register_write_override,
        .link_src, .link_soft_reset, .link_power_status_enable, .irq, .general_out_pins);
    hcgm_host_model host (.clk, .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
        .awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid),
        .wready(s_axi_wready), .bresp(s_axi_bresp), .bvalid(s_axi_bvalid), .bready(s_axi_bready),
        .araddr(s_axi_araddr), .arvalid(s_axi_arvalid), .arready(s_axi_arready),
        .rdata(s_axi_rdata), .rresp(s_axi_rresp), .rvalid(s_axi_rvalid), .rready(s_axi_rready));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ==========================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_ok(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [1:0] r;
        host.wr(a, d, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] re);
        logic [31:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, re});
    endtask
    // Outputs sampled mid-cycle so the edge's own updates have landed
    task automatic st_chk(input logic [2:0] e);
        @(negedge clk);
        chk({29'h0, irq, link_soft_reset, link_power_status_enable}, {29'h0, e});
    endtask
    task automatic set_src(input logic [14:0] v);
        @(posedge clk);
        link_src <= hcgm_src_t'(v);
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic touch_link(input logic running);
        @(posedge clk);
        link_clk_running <= running;
        link_reg_access <= 1'b1;
        @(posedge clk);
        link_reg_access <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    function automatic logic pick(input int p, input logic [4:0] c, input hcgm_src_t s);
        logic dflt;
        logic [15:0] lut;
        dflt = (p == 0) ? s.grf_empty : (p == 1) ? s.cycle_done : s.cycle_start;
        lut = {2'b10, s.packet_complete_flag, s.grf_confirm, s.fairness_gap, s.arbitration_gap,
            s.link_clk_half, s.ack_received, s.itf_empty, s.itf_full, s.atf_empty, s.atf_full,
            s.cycle_started, s.grf_empty, s.cycle_done, dflt};
        if (c == SEL_TOKEN)
            return s.token_at_head_flag;
        if (c[4])
            return (p == 2 && c[0]) ? s.cycle_started : dflt;
        return lut[c[3:0]];
    endfunction
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [1:0] r;
        rd_chk(ADDR_HOST_CTRL, 32'h0000_0004, RESP_OKAY);
        rd_chk(ADDR_PIN_SEL, PIN_SEL_RST, RESP_OKAY);
        st_chk(3'b001);
        set_src(15'h6800);
        chk({29'h0, general_out_pins}, 32'h0000_0007);
        set_src(15'h0000);
        host.wr(12'h104, 32'hFFFF_FFFF, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        rd_chk(12'h104, 32'h0000_0000, RESP_SLVERR);
        rd_chk(ADDR_HOST_CTRL, 32'h0000_0004, RESP_OKAY);
        $display("test reset done");
    endtask
    task automatic t_flag();
        wr_ok(ADDR_HOST_CTRL, 32'h0000_0002);
        touch_link(1'b1);
        rd_chk(ADDR_HOST_CTRL, 32'h0000_0006, RESP_OKAY);
        touch_link(1'b0);
        rd_chk(ADDR_HOST_CTRL, 32'h0000_0007, RESP_OKAY);
        st_chk(3'b101);
        wr_ok(ADDR_HOST_CTRL, 32'h0000_0002);
        rd_chk(ADDR_HOST_CTRL, 32'h0000_0007, RESP_OKAY);
        wr_ok(ADDR_HOST_CTRL, 32'h0000_0003);
        rd_chk(ADDR_HOST_CTRL, 32'h0000_0006, RESP_OKAY);
        st_chk(3'b001);
        wr_ok(ADDR_HOST_CTRL, 32'h0000_0000);
        touch_link(1'b0);
        rd_chk(ADDR_HOST_CTRL, 32'h0000_0005, RESP_OKAY);
        st_chk(3'b001);
        // Back onto the rising edge before touching a design input
        @(posedge clk);
        diag_register_write_override <= 1'b1;
        wr_ok(ADDR_HOST_CTRL, 32'h0000_0000);
        rd_chk(ADDR_HOST_CTRL, 32'h0000_0004, RESP_OKAY);
        diag_register_write_override <= 1'b0;
        link_clk_running <= 1'b1;
        $display("test flag done");
    endtask
    task automatic t_srst();
        wr_ok(ADDR_HOST_CTRL, 32'h0000_0008);
        rd_chk(ADDR_HOST_CTRL, 32'h0000_0008, RESP_OKAY);
        st_chk(3'b010);
        wr_ok(ADDR_HOST_CTRL, 32'h0000_000E);
        rd_chk(ADDR_HOST_CTRL, 32'h0000_0008, RESP_OKAY);
        wr_ok(ADDR_PIN_SEL, 32'hF800_0000);
        rd_chk(ADDR_PIN_SEL, 32'h0000_0000, RESP_OKAY);
        wr_ok(ADDR_HOST_CTRL, 32'h0000_0000);
        rd_chk(ADDR_HOST_CTRL, 32'h0000_0000, RESP_OKAY);
        wr_ok(ADDR_HOST_CTRL, 32'h0000_0004);
        st_chk(3'b001);
        $display("test soft reset done");
    endtask
    // Every code on all three pins, each source alone and none at all
    task automatic t_mux();
        logic [31:0] v;
        logic [2:0] e;
        for (int c = 0; c < 32; c++)
        begin
            v = {c[4:0], 3'h0, c[4:0], 3'h0, c[4:0], 11'h0};
            wr_ok(ADDR_PIN_SEL, v);
            rd_chk(ADDR_PIN_SEL, v, RESP_OKAY);
            for (int k = 0; k < 16; k++)
            begin
                set_src(15'h0001 << k);
                for (int p = 0; p < 3; p++)
                    e[p] = pick(p, c[4:0], hcgm_src_t'(15'h0001 << k));
                chk({29'h0, general_out_pins}, {29'h0, e});
            end
        end
        wr_ok(ADDR_PIN_SEL, 32'hFFFF_FFFF);
        rd_chk(ADDR_PIN_SEL, PIN_SEL_WMASK, RESP_OKAY);
        $display("test mux done");
    endtask
    // ==========================================================
    // Sequence, watchdog and verdict
    task automatic summarize();
        $display("compared=%0d errors=%0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        nrst = 1'b0;
        link_reg_access = 1'b0;
        link_clk_running = 1'b1;
        diag_register_write_override = 1'b0;
        link_src = '0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_flag();
        t_srst();
        t_mux();
        summarize();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        summarize();
    end
endmodule
